// ### hw/clr_cmd_dec.sv
// Command port decoder: latch, read-back, mode and count write strobes
`timescale 1ns/1ps
module clr_cmd_dec (
  input wire logic wr_en,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  clr_cmd_if.dec cmd
);
  logic [1:0] target;
  logic [1:0] fmt;

  assign target = wdata[clr_pkg::TARGET_SEL_HI:clr_pkg::TARGET_SEL_LO];
  assign fmt = wdata[clr_pkg::BYTE_FORMAT_HI:clr_pkg::BYTE_FORMAT_LO];

  always_comb begin
    cmd.mode_wr = 3'h0;
    cmd.cnt_lat = 3'h0;
    cmd.sts_lat = 3'h0;
    cmd.data_wr = 3'h0;
    cmd.wdata = wdata;
    if (wr_en && addr == clr_pkg::ADDR_CTRL) begin
      if (target == clr_pkg::TARGET_READBACK) begin
        for (int i = 0; i < clr_pkg::NUM_CNT; i++) begin
          if (wdata[clr_pkg::READBACK_PICK_ZERO + i]) begin
            cmd.cnt_lat[i] = ~wdata[clr_pkg::RB_COUNT_N];
            cmd.sts_lat[i] = ~wdata[clr_pkg::RB_STATUS_N];
          end
        end
      end else if (fmt == clr_pkg::FMT_LATCH) begin
        cmd.cnt_lat[target] = 1'b1;
      end else begin
        cmd.mode_wr[target] = 1'b1;
      end
    end else if (wr_en) begin
      cmd.data_wr[addr] = 1'b1;
    end
  end
endmodule

// ### hw/clr_cmd_if.sv
// Decoded command strobes passed from the command decoder to the counters
`timescale 1ns/1ps
interface clr_cmd_if;
  logic [2:0] mode_wr;
  logic [2:0] cnt_lat;
  logic [2:0] sts_lat;
  logic [2:0] data_wr;
  logic [7:0] wdata;
  modport dec (output mode_wr, output cnt_lat, output sts_lat, output data_wr, output wdata);
  modport ctl (input mode_wr, input cnt_lat, input sts_lat, input data_wr, input wdata);
endinterface

// ### hw/clr_pkg.sv
// Shared constants and types of the counter latch and read-back block
package clr_pkg;
  localparam int NUM_CNT = 3;
  localparam logic [1:0] ADDR_CNT0 = 2'h0;
  localparam logic [1:0] ADDR_CNT1 = 2'h1;
  localparam logic [1:0] ADDR_CNT2 = 2'h2;
  localparam logic [1:0] ADDR_CTRL = 2'h3;
  // Command byte field positions
  localparam int TARGET_SEL_HI = 7;
  localparam int TARGET_SEL_LO = 6;
  localparam int BYTE_FORMAT_HI = 5;
  localparam int BYTE_FORMAT_LO = 4;
  localparam int RB_COUNT_N = 5;
  localparam int RB_STATUS_N = 4;
  localparam int READBACK_PICK_ZERO = 1;
  localparam int MODE_MSB = 5;
  // Status byte field positions
  localparam int STS_OUT_BIT = 7;
  localparam int STS_PEND_BIT = 6;
  localparam logic [1:0] TARGET_READBACK = 2'h3;
  localparam logic [1:0] FMT_LATCH = 2'h0;
  localparam logic [1:0] FMT_LSB = 2'h1;
  localparam logic [1:0] FMT_MSB = 2'h2;
  localparam logic [1:0] FMT_BOTH = 2'h3;
  // Values after reset
  localparam logic [5:0] MODE_RST = 6'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  typedef enum logic {
    POS_LO = 1'b0,
    POS_HI = 1'b1
  } clr_pos_e;
endpackage

// ### hw/clr_rd_pick.sv
// Per-counter read byte selection and the flag updates a read causes
`timescale 1ns/1ps
module clr_rd_pick (
  input wire logic [1:0] fmt,
  input wire clr_pkg::clr_pos_e pos,
  input wire logic sts_latched,
  input wire logic cnt_latched,
  input wire logic [7:0] status,
  input wire logic [15:0] held,
  input wire logic [15:0] live,
  output logic [7:0] rd_byte,
  output logic next_sts_latched,
  output logic next_cnt_latched,
  output clr_pkg::clr_pos_e next_pos
);
  logic [15:0] value;

  assign value = cnt_latched ? held : live;

  always_comb begin
    rd_byte = value[7:0];
    next_sts_latched = sts_latched;
    next_cnt_latched = cnt_latched;
    next_pos = pos;
    if (sts_latched) begin
      rd_byte = status;
      next_sts_latched = 1'b0;
    end else begin
      case (fmt)
        clr_pkg::FMT_MSB: begin
          rd_byte = value[15:8];
          next_cnt_latched = 1'b0;
        end
        clr_pkg::FMT_BOTH: begin
          if (pos == clr_pkg::POS_LO) begin
            next_pos = clr_pkg::POS_HI;
          end else begin
            rd_byte = value[15:8];
            next_pos = clr_pkg::POS_LO;
            next_cnt_latched = 1'b0;
          end
        end
        default: begin
          next_cnt_latched = 1'b0;
        end
      endcase
    end
  end
endmodule

// ### hw/clr_top.sv
// Counter latch, read-back and status read path of a three-counter timer
`timescale 1ns/1ps
module clr_top (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [1:0] ADDR,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [7:0] WDATA,
  input wire logic [47:0] CE_COUNT,
  input wire logic [2:0] CE_OUT,
  input wire logic [2:0] CE_LOADED,
  output logic [7:0] RDATA,
  output logic RDATA_VALID,
  output wire logic [47:0] COUNT_HOLD,
  output wire logic [2:0] COUNT_LOAD,
  output wire logic [17:0] MODE_WORD,
  output wire logic [2:0] MODE_NEW,
  output wire logic [2:0] LOAD_PENDING
);

  // ----------------------------------------------------------------
  // Command decoding
  // ----------------------------------------------------------------
  clr_cmd_if cmd_bus ();

  clr_cmd_dec u_dec (
    .wr_en(WR_EN),
    .addr(ADDR),
    .wdata(WDATA),
    .cmd(cmd_bus.dec)
  );

  wire [7:0] rd_byte [3];

  // ----------------------------------------------------------------
  // Per-counter latch, status and byte sequencing
  // ----------------------------------------------------------------
  for (genvar i = 0; i < clr_pkg::NUM_CNT; i++) begin : g_ch
    logic [5:0] mode;
    logic [1:0] fmt;
    logic pend;
    logic [15:0] count_holding_reg;
    logic load;
    logic mode_new;
    clr_pkg::clr_pos_e wr_pos;
    clr_pkg::clr_pos_e rd_pos;
    clr_pkg::clr_pos_e next_rd_pos;
    logic cnt_latched;
    logic next_cnt_latched;
    logic [15:0] held;
    logic sts_latched;
    logic next_sts_latched;
    logic [7:0] status;
    logic [7:0] live_status;
    logic [15:0] live;
    logic rd_hit;
    logic wr_done;
    logic mode_wr;
    logic cnt_lat;
    logic sts_lat;
    logic data_wr;
    logic cnt_take;
    logic sts_take;

    // ------------------------------------------------------------
    // Strobes and live values of this counter
    // ------------------------------------------------------------
    // One strobe per counter, so a command aimed elsewhere leaves
    // every register of this counter untouched
    assign live = CE_COUNT[16*i +: 16];
    assign fmt = mode[clr_pkg::BYTE_FORMAT_HI:clr_pkg::BYTE_FORMAT_LO];
    assign rd_hit = RD_EN && (ADDR == 2'(i));
    assign mode_wr = cmd_bus.mode_wr[i];
    assign cnt_lat = cmd_bus.cnt_lat[i];
    assign sts_lat = cmd_bus.sts_lat[i];
    assign data_wr = cmd_bus.data_wr[i];

    // A request to a latch still unread is refused, the first capture stands
    assign cnt_take = cnt_lat && !cnt_latched;
    assign sts_take = sts_lat && !sts_latched;

    // A count is complete on a one-byte write or on the second byte
    assign wr_done = data_wr && (fmt != clr_pkg::FMT_BOTH || wr_pos == clr_pkg::POS_HI);

    // ------------------------------------------------------------
    // Status as it would be captured right now
    // ------------------------------------------------------------
    always_comb begin
      live_status = clr_pkg::BYTE_ZERO;
      live_status[clr_pkg::STS_OUT_BIT] = CE_OUT[i];
      live_status[clr_pkg::STS_PEND_BIT] = pend;
      live_status[clr_pkg::MODE_MSB:0] = mode;
    end

    // ------------------------------------------------------------
    // Programmed mode
    // ------------------------------------------------------------
    // Latch commands never reach this register, only mode words do
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        mode <= clr_pkg::MODE_RST;
      end else if (mode_wr) begin
        mode <= cmd_bus.wdata[clr_pkg::MODE_MSB:0];
      end
    end

    // Tells the counting element that a new mode word has arrived
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        mode_new <= 1'b0;
      end else begin
        mode_new <= mode_wr;
      end
    end

    // ------------------------------------------------------------
    // Count holding register and write byte order
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        wr_pos <= clr_pkg::POS_LO;
      end else if (mode_wr) begin
        wr_pos <= clr_pkg::POS_LO;
      end else if (data_wr && fmt == clr_pkg::FMT_BOTH) begin
        wr_pos <= (wr_pos == clr_pkg::POS_LO) ? clr_pkg::POS_HI : clr_pkg::POS_LO;
      end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        count_holding_reg <= clr_pkg::COUNT_RST;
      end else if (data_wr) begin
        case (fmt)
          clr_pkg::FMT_MSB: begin
            count_holding_reg <= {cmd_bus.wdata, clr_pkg::BYTE_ZERO};
          end
          clr_pkg::FMT_BOTH: begin
            if (wr_pos == clr_pkg::POS_LO) begin
              count_holding_reg[7:0] <= cmd_bus.wdata;
            end else begin
              count_holding_reg[15:8] <= cmd_bus.wdata;
            end
          end
          default: begin
            count_holding_reg <= {clr_pkg::BYTE_ZERO, cmd_bus.wdata};
          end
        endcase
      end
    end

    // ------------------------------------------------------------
    // Count write completion
    // ------------------------------------------------------------
    // The pulse follows the byte that completes the count by one cycle
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        load <= 1'b0;
      end else begin
        load <= wr_done;
      end
    end

    // ------------------------------------------------------------
    // Load-pending flag
    // ------------------------------------------------------------
    // A new write in the same cycle as a load wins: that count is not yet loaded
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        pend <= 1'b0;
      end else if (mode_wr) begin
        pend <= 1'b1;
      end else if (wr_done) begin
        pend <= 1'b1;
      end else if (CE_LOADED[i]) begin
        pend <= 1'b0;
      end
    end

    // ------------------------------------------------------------
    // Count output latch
    // ------------------------------------------------------------
    // Until loaded, the element still holds the old count, so that is what is caught
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        cnt_latched <= 1'b0;
      end else if (mode_wr) begin
        cnt_latched <= 1'b0;
      end else if (cnt_lat) begin
        cnt_latched <= 1'b1;
      end else if (rd_hit) begin
        cnt_latched <= next_cnt_latched;
      end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        held <= clr_pkg::COUNT_RST;
      end else if (cnt_take) begin
        held <= live;
      end
    end

    // ------------------------------------------------------------
    // Status latch
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        sts_latched <= 1'b0;
      end else if (mode_wr) begin
        sts_latched <= 1'b0;
      end else if (sts_lat) begin
        sts_latched <= 1'b1;
      end else if (rd_hit) begin
        sts_latched <= next_sts_latched;
      end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        status <= clr_pkg::BYTE_ZERO;
      end else if (sts_take) begin
        status <= live_status;
      end
    end

    // ------------------------------------------------------------
    // Read byte order
    // ------------------------------------------------------------
    // Kept per counter, so other counters may be touched between the bytes
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        rd_pos <= clr_pkg::POS_LO;
      end else if (mode_wr) begin
        rd_pos <= clr_pkg::POS_LO;
      end else if (rd_hit) begin
        rd_pos <= next_rd_pos;
      end
    end

    clr_rd_pick u_pick (
      .fmt(fmt),
      .pos(rd_pos),
      .sts_latched(sts_latched),
      .cnt_latched(cnt_latched),
      .status(status),
      .held(held),
      .live(live),
      .rd_byte(rd_byte[i]),
      .next_sts_latched(next_sts_latched),
      .next_cnt_latched(next_cnt_latched),
      .next_pos(next_rd_pos)
    );

    // ------------------------------------------------------------
    // Outputs toward the counting elements
    // ------------------------------------------------------------
    assign COUNT_HOLD[16*i +: 16] = count_holding_reg;
    assign COUNT_LOAD[i] = load;
    assign MODE_WORD[6*i +: 6] = mode;
    assign MODE_NEW[i] = mode_new;
    assign LOAD_PENDING[i] = pend;
  end

  // ----------------------------------------------------------------
  // Read data register
  // ----------------------------------------------------------------
  // The command port is write only; reading it returns zero
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      RDATA <= clr_pkg::BYTE_ZERO;
    end else if (RD_EN) begin
      if (ADDR == clr_pkg::ADDR_CNT0) begin
        RDATA <= rd_byte[0];
      end else if (ADDR == clr_pkg::ADDR_CNT1) begin
        RDATA <= rd_byte[1];
      end else if (ADDR == clr_pkg::ADDR_CNT2) begin
        RDATA <= rd_byte[2];
      end else begin
        RDATA <= clr_pkg::BYTE_ZERO;
      end
    end
  end

  // Exactly one cycle after the strobe; nothing on this bus ever waits
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      RDATA_VALID <= 1'b0;
    end else begin
      RDATA_VALID <= RD_EN;
    end
  end

endmodule

// ### verification/clr_ce_model.sv
// Counting element model for the three counters
`timescale 1ns/1ps
module clr_ce_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic run,
  input wire logic hold,
  input wire logic [47:0] count_hold,
  input wire logic [2:0] count_load,
  output logic [47:0] ce_count,
  output logic [2:0] ce_loaded
);
  logic [2:0] wait_load;
  // Hold delays the load so the bench can see the pending window
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ce_count <= 48'h0;
      ce_loaded <= 3'h0;
      wait_load <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        ce_loaded[i] <= 1'b0;
        if (count_load[i]) begin
          wait_load[i] <= 1'b1;
        end
        if (wait_load[i] && !hold) begin
          ce_count[16*i +: 16] <= count_hold[16*i +: 16];
          ce_loaded[i] <= 1'b1;
          wait_load[i] <= count_load[i];
        end else if (run) begin
          ce_count[16*i +: 16] <= ce_count[16*i +: 16] - 16'h1;
        end
      end
    end
  end
endmodule

// ### verification/clr_top_checker.sv
// Port assertions for the counter latch and read-back block
`timescale 1ns/1ps
module clr_top_checker (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [1:0] ADDR,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [7:0] WDATA,
  input wire logic [2:0] CE_LOADED,
  input wire logic [7:0] RDATA,
  input wire logic RDATA_VALID,
  input wire logic [2:0] COUNT_LOAD,
  input wire logic [17:0] MODE_WORD,
  input wire logic [2:0] MODE_NEW,
  input wire logic [2:0] LOAD_PENDING
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // ------------------------------------------
  // Command decode, read answer and load-pending flags
  // ------------------------------------------
  sequence s_mode_wr;
    WR_EN && ADDR == 2'h3 && WDATA[5:4] != 2'h0 && WDATA[7:6] != 2'h3;
  endsequence
  sequence s_latch_wr;
    WR_EN && ADDR == 2'h3 && WDATA[5:4] == 2'h0 && WDATA[7:6] != 2'h3;
  endsequence
  AST_RD_ANSWER: assert property (RD_EN |=> RDATA_VALID)
    else $error("read strobe not answered");
  AST_NO_STRAY_VALID: assert property (RDATA_VALID |-> $past(RD_EN))
    else $error("read data valid without a read");
  AST_CTRL_RD_ZERO: assert property (RD_EN && ADDR == 2'h3 |=> RDATA == 8'h00)
    else $error("command port read not zero");
  AST_MODE_NEW: assert property (s_mode_wr |=> MODE_NEW == 3'h1 << $past(WDATA[7:6]))
    else $error("mode write strobe on wrong counter");
  AST_MODE_WORD: assert property (
    s_mode_wr |=> MODE_WORD[$past(WDATA[7:6]) * 6 +: 6] == $past(WDATA[5:0]))
    else $error("mode fields not stored");
  AST_LATCH_KEEPS_MODE: assert property (
    s_latch_wr |=> $stable(MODE_WORD) && MODE_NEW == 3'h0)
    else $error("latch command changed the mode");
  AST_PEND_ON_MODE: assert property (s_mode_wr |=> LOAD_PENDING[$past(WDATA[7:6])])
    else $error("mode write left load pending clear");
  AST_PEND_ON_LOAD: assert property (
    COUNT_LOAD != 3'h0 |-> (LOAD_PENDING & COUNT_LOAD) == COUNT_LOAD)
    else $error("count write left load pending clear");
  AST_PEND_CLEAR: assert property (
    CE_LOADED != 3'h0 && !WR_EN |=> (LOAD_PENDING & $past(CE_LOADED)) == 3'h0)
    else $error("load pending not cleared by load");
  AST_PEND_OTHERS: assert property (
    s_mode_wr ##0 (CE_LOADED == 3'h0) |=>
      (LOAD_PENDING & ~MODE_NEW) == ($past(LOAD_PENDING) & ~MODE_NEW))
    else $error("mode write touched another load pending flag");
  AST_PEND_STABLE: assert property (
    !WR_EN && CE_LOADED == 3'h0 |=> $stable(LOAD_PENDING))
    else $error("load pending changed with no write and no load");
  AST_LOAD_AFTER_WRITE: assert property (
    COUNT_LOAD != 3'h0 |-> $past(WR_EN) && (COUNT_LOAD == (3'h1 << $past(ADDR))))
    else $error("count load pulse without a count write");
  AST_RDATA_HOLD: assert property (!RD_EN |=> $stable(RDATA))
    else $error("read data changed without a read");
endmodule
bind clr_top clr_top_checker u_chk (.CLK, .RESETN, .ADDR, .WR_EN, .RD_EN, .WDATA,
  .CE_LOADED, .RDATA, .RDATA_VALID, .COUNT_LOAD, .MODE_WORD, .MODE_NEW, .LOAD_PENDING);

// ### verification/clr_top_tb.sv
// Self-checking bench for the counter latch and read-back block
`timescale 1ns/1ps
module clr_top_tb;
  logic CLK, RESETN, WR_EN, RD_EN, RDATA_VALID, run, hold;
  logic [1:0] ADDR;
  logic [7:0] WDATA, RDATA;
  logic [2:0] CE_OUT, CE_LOADED, COUNT_LOAD, MODE_NEW, LOAD_PENDING;
  logic [47:0] CE_COUNT, COUNT_HOLD;
  logic [17:0] MODE_WORD;
  logic [15:0] held, held2;
  int n_fail, check_count;
  clr_top u_dut (.CLK, .RESETN, .ADDR, .WR_EN, .RD_EN, .WDATA, .CE_COUNT, .CE_OUT,
    .CE_LOADED, .RDATA, .RDATA_VALID, .COUNT_HOLD, .COUNT_LOAD, .MODE_WORD, .MODE_NEW,
    .LOAD_PENDING);
  clr_ce_model u_ce (.clk(CLK), .resetn(RESETN), .run(run), .hold(hold),
    .count_hold(COUNT_HOLD), .count_load(COUNT_LOAD), .ce_count(CE_COUNT),
    .ce_loaded(CE_LOADED));
  // ------------------------------------------
  // Host bus tasks
  // ------------------------------------------
  task automatic chk(input string name, input logic [17:0] seen, input logic [17:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(negedge CLK);
    WR_EN = 1'b1;
    ADDR = a;
    WDATA = d;
    @(negedge CLK);
    WR_EN = 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(negedge CLK);
    RD_EN = 1'b1;
    ADDR = a;
    @(negedge CLK);
    RD_EN = 1'b0;
    chk("RDATA_VALID", RDATA_VALID, 1'b1);
    chk("RDATA", RDATA, exp);
  endtask
  // Both bytes always read, so no pair is left half done
  task automatic rd16(input logic [1:0] a, input logic [15:0] v);
    rd(a, v[7:0]);
    rd(a, v[15:8]);
  endtask
  task automatic spin(input int n);
    run = 1'b1;
    repeat (n) @(negedge CLK);
    run = 1'b0;
  endtask
  // ------------------------------------------
  // Scenarios
  // ------------------------------------------
  task automatic t_latch;
    for (int i = 0; i < 3; i++) begin
      wr(2'h3, {i[1:0], 6'h34});
      wr(i[1:0], 8'h21);
      wr(i[1:0], 8'h43);
      repeat (4) @(negedge CLK);
      wr(2'h3, {i[1:0], 6'h00});
      spin(5);
      wr(2'h3, {i[1:0], 6'h00});
      chk("MODE_WORD", MODE_WORD[6*i +: 6], 6'h34);
      rd16(i[1:0], 16'h4321);
      rd16(i[1:0], CE_COUNT[16*i +: 16]);
    end
    rd(2'h3, 8'h00);
  endtask
  task automatic t_inter;
    held = CE_COUNT[31:16];
    wr(2'h3, 8'h40);
    spin(3);
    rd(2'h1, held[7:0]);
    wr(2'h1, 8'haa);
    wr(2'h3, 8'h34);
    rd(2'h2, CE_COUNT[39:32]);
    rd(2'h1, held[15:8]);
    wr(2'h1, 8'hbb);
    @(negedge CLK);
    chk("COUNT_HOLD", COUNT_HOLD[31:16], 16'hbbaa);
    rd(2'h2, CE_COUNT[47:40]);
  endtask
  task automatic t_rback;
    CE_OUT = 3'h5;
    repeat (4) @(negedge CLK);
    held = CE_COUNT[15:0];
    held2 = CE_COUNT[47:32];
    wr(2'h3, 8'hca);
    spin(2);
    CE_OUT = 3'h2;
    wr(2'h3, 8'hee);
    rd(2'h1, 8'hb4);
    rd16(2'h1, CE_COUNT[31:16]);
    rd(2'h2, 8'hb4);
    rd16(2'h2, held2);
    rd16(2'h2, CE_COUNT[47:32]);
    rd(2'h0, 8'hf4);
    rd16(2'h0, held);
  endtask
  task automatic t_pend;
    hold = 1'b1;
    wr(2'h3, 8'h74);
    @(negedge CLK);
    chk("LOAD_PENDING", LOAD_PENDING, 3'h3);
    wr(2'h1, 8'h11);
    wr(2'h1, 8'h22);
    hold = 1'b0;
    repeat (4) @(negedge CLK);
    chk("LOAD_PENDING", LOAD_PENDING, 3'h1);
    hold = 1'b1;
    wr(2'h1, 8'h33);
    repeat (2) @(negedge CLK);
    chk("LOAD_PENDING", LOAD_PENDING, 3'h1);
    wr(2'h1, 8'h44);
    repeat (2) @(negedge CLK);
    chk("LOAD_PENDING", LOAD_PENDING, 3'h3);
    CE_OUT = 3'h0;
    wr(2'h3, 8'he4);
    CE_OUT = 3'h2;
    wr(2'h3, 8'he4);
    wr(2'h3, 8'hc4);
    rd(2'h1, 8'h74);
    rd16(2'h1, 16'h2211);
    hold = 1'b0;
    repeat (4) @(negedge CLK);
    rd16(2'h1, 16'h4433);
  endtask
  // One-byte formats, status before a single count byte, unlatch by reprogramming
  task automatic t_onebyte;
    wr(2'h3, 8'h90);
    wr(2'h2, 8'h5a);
    repeat (4) @(negedge CLK);
    chk("COUNT_HOLD", COUNT_HOLD[47:32], 16'h005a);
    chk("LOAD_PENDING", LOAD_PENDING, 3'h1);
    wr(2'h3, 8'hc8);
    spin(2);
    rd(2'h2, 8'h10);
    rd(2'h2, 8'h5a);
    rd(2'h2, 8'h58);
    wr(2'h3, 8'ha0);
    wr(2'h2, 8'h7e);
    repeat (4) @(negedge CLK);
    wr(2'h3, 8'h80);
    spin(1);
    rd(2'h2, 8'h7e);
    rd(2'h2, 8'h7d);
    wr(2'h3, 8'h80);
    wr(2'h3, 8'h90);
    spin(1);
    rd(2'h2, 8'hfe);
  endtask
  // Reset in mid-run clears the status latch, the mode and the pending flags
  task automatic t_reset;
    wr(2'h3, 8'he2);
    @(negedge CLK);
    RESETN = 1'b0;
    repeat (2) @(negedge CLK);
    chk("MODE_WORD", MODE_WORD, 18'h0);
    chk("LOAD_PENDING", LOAD_PENDING, 3'h0);
    RESETN = 1'b1;
    rd(2'h0, 8'h00);
    wr(2'h3, 8'h10);
    @(negedge CLK);
    chk("LOAD_PENDING", LOAD_PENDING, 3'h1);
  endtask
  task automatic complete_run;
    if (n_fail == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  // Guard against a hang
  initial begin
    repeat (20000) @(posedge CLK);
    n_fail++;
    complete_run;
  end
  initial begin
    {RESETN, WR_EN, RD_EN, run, hold, ADDR, WDATA, CE_OUT} = '0;
    n_fail = 0;
    check_count = 0;
    repeat (12) @(negedge CLK);
    RESETN = 1'b1;
    t_latch;
    t_inter;
    t_rback;
    t_pend;
    t_onebyte;
    t_reset;
    complete_run;
  end
endmodule
